// ### include/tx_cell_pkg.sv
// Contract
// - Count load sets the count-transfer flag
// - Reading count status clears transfer flag
// - Load while transfer flag set raises overrun
// - Reading count status clears overrun flag
// - Transfer flag with enable drives interrupt
// - Start-of-cell off word zero flags misplacement
// - Start-of-cell is taken as word zero, write pointer then one
// - Reading interrupt status clears three flags
// - Write into full FIFO flags overflow
// - Bus parity error flagged, sense selectable
// - Misplaced start-of-cell interrupts when enabled
// - FIFO overflow interrupts when enabled
// - Parity disabled still flags, no interrupt
// - Idle cells sent when FIFO empty
// - Idle header octet one carries GFC
// - Idle octet four carries PTI, CLP
// - Idle VPI and VCI all zero
// - Idle payload octets carry pattern, MSB first
// - Load copies counter, restarts at 1/0
// - Only FIFO cells counted, not idle
package tx_cell_pkg;

	localparam int DATA_W      = 16;
	localparam int CELL_WORDS  = 27;
	localparam int FIFO_CELLS  = 4;
	localparam int COUNT_W     = 19;
	localparam int CELL_OCTETS = 53;
	localparam int HCS_OCTET   = 4;
	localparam int ADDR_W      = 12;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_CONFIG1     = 8'h80;
	localparam logic [7:0] IDX_COUNT_STAT  = 8'h82;
	localparam logic [7:0] IDX_INT_EN_STAT = 8'h83;
	localparam logic [7:0] IDX_IDLE_HDR    = 8'h84;
	localparam logic [7:0] IDX_IDLE_PAY    = 8'h85;
	localparam logic [7:0] IDX_COUNT_LOW   = 8'h86;
	localparam logic [7:0] IDX_COUNT_MID   = 8'h87;
	localparam logic [7:0] IDX_COUNT_HIGH  = 8'h88;

	localparam logic [7:0] CONFIG1_RST    = 8'h04;
	localparam logic [7:0] COUNT_STAT_RST = 8'h08;
	localparam logic [7:0] COUNT_STAT_WR  = 8'h8F;
	localparam logic [2:0] INT_EN_RST     = 3'h0;
	localparam logic [7:0] IDLE_HDR_RST   = 8'h01;
	localparam logic [7:0] IDLE_PAY_RST   = 8'h6A;

	localparam int PARITY_SENSE_BIT = 7;
	localparam int XFER_EN_BIT      = 7;
	localparam int INT_EN_LSB       = 5;

	typedef struct packed {
		logic              wr;
		logic              soc;
		logic              par;
		logic [DATA_W-1:0] data;
	} tx_word_type;

	typedef struct packed {
		logic [3:0] gfc;
		logic [2:0] pti;
		logic       clp;
	} idle_hdr_type;

	typedef struct packed {
		logic       valid;
		logic       first;
		logic       idle;
		logic [7:0] octet;
	} line_octet_type;

endpackage

// ### verilog/bus_word_check.sv
`timescale 1ns/100ps
module bus_word_check (
	input  wire logic                  clk_in,
	input  wire logic                  arst_n_in,
	input  wire tx_cell_pkg::tx_word_type pin_word_in,
	input  wire logic                  parity_sense_in,
	output tx_cell_pkg::tx_word_type   word_out,
	output logic                       parity_error_out
);
	tx_cell_pkg::tx_word_type meta_q;
	tx_cell_pkg::tx_word_type sync_q;

	// Bus pins come from the cell source's timing, two stages first
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= pin_word_in;
			sync_q <= meta_q;
		end
	end

	assign word_out = sync_q;
	// Odd sense wants xor of one, even sense wants zero
	assign parity_error_out = sync_q.wr &&
		((^{sync_q.data, sync_q.par}) == parity_sense_in);
endmodule

// ### verilog/idle_cell_gen.sv
`timescale 1ns/100ps
module idle_cell_gen (
	input  wire logic                       clk_in,
	input  wire logic                       arst_n_in,
	input  wire logic                       start_in,
	input  wire logic                       from_fifo_in,
	input  wire tx_cell_pkg::idle_hdr_type  hdr_in,
	input  wire logic [7:0]                 pattern_in,
	output logic                            busy_out,
	output tx_cell_pkg::line_octet_type     octet_out
);
	logic [5:0] idx_q;
	logic       fifo_q;
	logic [7:0] octet_d;

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			busy_out <= 1'b0;
			idx_q    <= 6'h00;
			fifo_q   <= 1'b0;
		end else if (start_in && !busy_out) begin
			busy_out <= 1'b1;
			idx_q    <= 6'h00;
			fifo_q   <= from_fifo_in;
		end else if (busy_out) begin
			if (idx_q == 6'(tx_cell_pkg::CELL_OCTETS - 1)) begin
				busy_out <= 1'b0;
			end
			idx_q <= idx_q + 6'h01;
		end
	end

	// HCS is added further down the line, so its slot leaves as zero
	always_comb begin
		octet_d = pattern_in;
		unique case (idx_q)
			6'h00: octet_d = {hdr_in.gfc, 4'h0};
			6'h01, 6'h02: octet_d = 8'h00;
			6'h03: octet_d = {4'h0, hdr_in.pti, hdr_in.clp};
			6'(tx_cell_pkg::HCS_OCTET): octet_d = 8'h00;
			default: octet_d = pattern_in;
		endcase
		if (fifo_q) begin
			octet_d = 8'h00;
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			octet_out <= '0;
		end else begin
			octet_out.valid <= busy_out;
			octet_out.first <= busy_out && (idx_q == 6'h00);
			octet_out.idle  <= busy_out && !fifo_q;
			octet_out.octet <= busy_out ? octet_d : 8'h00;
		end
	end
endmodule

// ### verilog/tx_cell_status_idle_fill.sv
`timescale 1ns/100ps
module tx_cell_status_idle_fill #(
	parameter int CELL_WORDS = tx_cell_pkg::CELL_WORDS,
	parameter int FIFO_CELLS = tx_cell_pkg::FIFO_CELLS
) (
	input  wire logic                          clk_in,
	input  wire logic                          arst_n_in,
	input  wire logic                          psel_in,
	input  wire logic                          penable_in,
	input  wire logic                          pwrite_in,
	input  wire logic [tx_cell_pkg::ADDR_W-1:0] paddr_in,
	input  wire logic [31:0]                   pwdata_in,
	output logic [31:0]                        prdata_out,
	output logic                               pready_out,
	output logic                               pslverr_out,
	input  wire logic                          tx_write_enable_in,
	input  wire logic                          tx_start_of_cell_in,
	input  wire logic [tx_cell_pkg::DATA_W-1:0] tx_cell_data_bus_in,
	input  wire logic                          tx_parity_in,
	input  wire logic                          global_monitor_update_in,
	input  wire logic                          cell_slot_in,
	output logic                               irq_out,
	output logic [7:0]                         line_octet_out,
	output logic                               line_octet_valid_out,
	output logic                               line_cell_first_out,
	output logic                               line_idle_cell_out
);
	localparam int PTR_W = $clog2(CELL_WORDS);
	localparam int FILL_W = $clog2(FIFO_CELLS + 1);
	localparam int CW = tx_cell_pkg::COUNT_W;

	// Software registers
	logic [7:0] config1_q;
	logic [7:0] count_stat_q;
	logic [2:0] int_en_q;
	logic [7:0] idle_hdr_q;
	logic [7:0] idle_pay_q;

	// Hardware-set flags
	logic xfer_flag_q;
	logic overrun_flag_q;
	logic soc_flag_q;
	logic fovr_flag_q;
	logic par_flag_q;
	logic [2:0] int_flag_q;
	logic [2:0] int_set;

	// Bus slave state
	logic [7:0] reg_idx;
	logic       addr_ok;
	logic       mapped;
	logic       access;
	logic       done;
	logic       wr_done;
	logic       rd_done;
	logic [7:0] rdata;
	logic [7:0] rd_capt_q;

	// Cell path state
	tx_cell_pkg::tx_word_type     pin_word;
	tx_cell_pkg::tx_word_type     word;
	tx_cell_pkg::line_octet_type  octet;
	logic                         parity_error;
	logic [PTR_W-1:0]             wptr_q;
	logic [FILL_W-1:0]            fill_q;
	logic                         fifo_full;
	logic                         word_taken;
	logic                         cell_done;
	logic                         gen_busy;
	logic                         cell_start;
	logic                         from_fifo;
	logic                         count_event;
	logic                         load;
	logic [CW-1:0]                cnt_q;
	logic [CW-1:0]                count_q;

	// Set terms and clear terms of the flags
	logic xfer_set;
	logic ovr_set;
	logic soc_set;
	logic fovr_set;
	logic par_set;
	logic stat_clr;
	logic int_clr;
	logic irq_d;

	// ---------------- Register bus ----------------

	assign reg_idx = paddr_in[9:2];
	assign addr_ok = (paddr_in[tx_cell_pkg::ADDR_W-1:10] == '0) && (paddr_in[1:0] == 2'h0);
	assign access  = psel_in && penable_in;
	assign done    = access && pready_out;
	assign wr_done = done && pwrite_in && mapped;
	assign rd_done = done && !pwrite_in && mapped;

	always_comb begin
		mapped = addr_ok;
		rdata  = 8'h00;
		unique case (reg_idx)
			tx_cell_pkg::IDX_CONFIG1:
				rdata = config1_q;
			tx_cell_pkg::IDX_COUNT_STAT:
				rdata = {count_stat_q[7], xfer_flag_q, overrun_flag_q, 1'b0,
					count_stat_q[3:0]};
			tx_cell_pkg::IDX_INT_EN_STAT:
				rdata = {int_en_q, 2'h0, par_flag_q, fovr_flag_q, soc_flag_q};
			tx_cell_pkg::IDX_IDLE_HDR:
				rdata = idle_hdr_q;
			tx_cell_pkg::IDX_IDLE_PAY:
				rdata = idle_pay_q;
			tx_cell_pkg::IDX_COUNT_LOW:
				rdata = count_q[7:0];
			tx_cell_pkg::IDX_COUNT_MID:
				rdata = count_q[15:8];
			tx_cell_pkg::IDX_COUNT_HIGH:
				rdata = {5'h00, count_q[CW-1:16]};
			default:
				mapped = 1'b0;
		endcase
	end

	// One wait state lets read data leave straight from a flop
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pready_out  <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out  <= 32'h0000_0000;
			rd_capt_q   <= 8'h00;
		end else if (access && !pready_out) begin
			pready_out  <= 1'b1;
			pslverr_out <= !mapped;
			prdata_out  <= (mapped && !pwrite_in) ? {24'h00_0000, rdata} : 32'h0000_0000;
			rd_capt_q   <= rdata;
		end else begin
			pready_out  <= 1'b0;
			pslverr_out <= 1'b0;
		end
	end

	// Reserved bits are stored as written, except count status and interrupt enable, which drop theirs; software keeps them at default
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			config1_q    <= tx_cell_pkg::CONFIG1_RST;
			count_stat_q <= tx_cell_pkg::COUNT_STAT_RST;
			int_en_q     <= tx_cell_pkg::INT_EN_RST;
			idle_hdr_q   <= tx_cell_pkg::IDLE_HDR_RST;
			idle_pay_q   <= tx_cell_pkg::IDLE_PAY_RST;
		end else if (wr_done) begin
			unique case (reg_idx)
				tx_cell_pkg::IDX_CONFIG1:
					config1_q <= pwdata_in[7:0];
				tx_cell_pkg::IDX_COUNT_STAT:
					count_stat_q <= pwdata_in[7:0] & tx_cell_pkg::COUNT_STAT_WR;
				tx_cell_pkg::IDX_INT_EN_STAT:
					int_en_q <= pwdata_in[7:tx_cell_pkg::INT_EN_LSB];
				tx_cell_pkg::IDX_IDLE_HDR:
					idle_hdr_q <= pwdata_in[7:0];
				tx_cell_pkg::IDX_IDLE_PAY:
					idle_pay_q <= pwdata_in[7:0];
				default: ;
			endcase
		end
	end

	// ---------------- Cell write side ----------------

	assign pin_word = '{wr: tx_write_enable_in, soc: tx_start_of_cell_in,
		par: tx_parity_in, data: tx_cell_data_bus_in};

	bus_word_check u_bus_word_check (
		.clk_in           (clk_in),
		.arst_n_in        (arst_n_in),
		.pin_word_in      (pin_word),
		.parity_sense_in  (config1_q[tx_cell_pkg::PARITY_SENSE_BIT]),
		.word_out         (word),
		.parity_error_out (parity_error)
	);

	assign fifo_full  = (fill_q == FILL_W'(FIFO_CELLS));
	assign word_taken = word.wr && !fifo_full;
	// A start word is word zero, so a cell can close on the last word only
	assign cell_done  = word_taken && !word.soc && (wptr_q == PTR_W'(CELL_WORDS - 1));

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			wptr_q <= '0;
		end else if (word.wr && word.soc) begin
			wptr_q <= word_taken ? PTR_W'(1) : '0;
		end else if (cell_done) begin
			wptr_q <= '0;
		end else if (word_taken) begin
			wptr_q <= wptr_q + PTR_W'(1);
		end
	end

	// ---------------- Line side ----------------

	assign cell_start  = cell_slot_in && !gen_busy;
	assign from_fifo   = (fill_q != '0);
	assign count_event = cell_start && from_fifo;

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			fill_q <= '0;
		end else if (cell_done && !count_event) begin
			fill_q <= fill_q + FILL_W'(1);
		end else if (count_event && !cell_done) begin
			fill_q <= fill_q - FILL_W'(1);
		end
	end

	idle_cell_gen u_idle_cell_gen (
		.clk_in       (clk_in),
		.arst_n_in    (arst_n_in),
		.start_in     (cell_start),
		.from_fifo_in (from_fifo),
		.hdr_in       (tx_cell_pkg::idle_hdr_type'(idle_hdr_q)),
		.pattern_in   (idle_pay_q),
		.busy_out     (gen_busy),
		.octet_out    (octet)
	);

	assign line_octet_out       = octet.octet;
	assign line_octet_valid_out = octet.valid;
	assign line_cell_first_out  = octet.first;
	assign line_idle_cell_out   = octet.idle;

	// ---------------- Cell count ----------------

	assign load = global_monitor_update_in || (wr_done &&
		(reg_idx >= tx_cell_pkg::IDX_COUNT_LOW) && (reg_idx <= tx_cell_pkg::IDX_COUNT_HIGH));

	// Counter sticks at its top rather than wrap if software never polls
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cnt_q   <= '0;
			count_q <= '0;
		end else if (load) begin
			count_q <= cnt_q;
			cnt_q   <= count_event ? CW'(1) : '0;
		end else if (count_event && (cnt_q != '1)) begin
			cnt_q <= cnt_q + CW'(1);
		end
	end

	// ---------------- Status flags ----------------

	assign xfer_set = load;
	assign ovr_set  = load && xfer_flag_q;
	assign soc_set  = word.wr && word.soc && (wptr_q != '0);
	assign fovr_set = word.wr && fifo_full;
	assign par_set  = parity_error;
	// Only bits already shown to software are cleared by its read
	assign stat_clr = rd_done && (reg_idx == tx_cell_pkg::IDX_COUNT_STAT);
	assign int_clr  = rd_done && (reg_idx == tx_cell_pkg::IDX_INT_EN_STAT);

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			xfer_flag_q    <= 1'b0;
			overrun_flag_q <= 1'b0;
		end else begin
			xfer_flag_q    <= xfer_set || (xfer_flag_q && !(stat_clr && rd_capt_q[6]));
			overrun_flag_q <= ovr_set || (overrun_flag_q && !(stat_clr && rd_capt_q[5]));
		end
	end

	// Bit order matches the status field: misplaced start, overflow, parity
	assign int_set = {par_set, fovr_set, soc_set};

	for (genvar i = 0; i < 3; i++) begin : g_int_flag
		always_ff @(posedge clk_in or negedge arst_n_in) begin
			if (!arst_n_in) begin
				int_flag_q[i] <= 1'b0;
			end else begin
				int_flag_q[i] <= int_set[i] || (int_flag_q[i] && !(int_clr && rd_capt_q[i]));
			end
		end
	end

	assign soc_flag_q  = int_flag_q[0];
	assign fovr_flag_q = int_flag_q[1];
	assign par_flag_q  = int_flag_q[2];

	// ---------------- Interrupt ----------------

	assign irq_d = (xfer_flag_q && count_stat_q[tx_cell_pkg::XFER_EN_BIT]) ||
		(soc_flag_q && int_en_q[0]) ||
		(fovr_flag_q && int_en_q[1]) ||
		(par_flag_q && int_en_q[2]);

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= irq_d;
		end
	end

endmodule

// ### tb/tx_cell_status_idle_fill_asserts.sv
`timescale 1ns/100ps
module tx_cell_asserts (
	input wire logic                            clk_in,
	input wire logic                            arst_n_in,
	input wire logic                            psel_in,
	input wire logic                            penable_in,
	input wire logic                            pwrite_in,
	input wire logic [tx_cell_pkg::ADDR_W-1:0]  paddr_in,
	input wire logic [31:0]                     pwdata_in,
	input wire logic                            pready_out,
	input wire logic                            pslverr_out,
	input wire logic                            irq_out,
	input wire logic [7:0]                      line_octet_out,
	input wire logic                            line_octet_valid_out,
	input wire logic                            line_cell_first_out,
	input wire logic                            line_idle_cell_out
);
	logic [7:0] hdr_q;
	logic [7:0] pat_q;
	logic [5:0] idx_q;
	logic       done;
	assign done = psel_in && penable_in && pready_out;
	// Shadow copies; only valid while software leaves them alone mid-cell
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			hdr_q <= tx_cell_pkg::IDLE_HDR_RST;
			pat_q <= tx_cell_pkg::IDLE_PAY_RST;
		end else if (done && pwrite_in && !pslverr_out) begin
			if (paddr_in == {2'h0, tx_cell_pkg::IDX_IDLE_HDR, 2'h0})
				hdr_q <= pwdata_in[7:0];
			if (paddr_in == {2'h0, tx_cell_pkg::IDX_IDLE_PAY, 2'h0})
				pat_q <= pwdata_in[7:0];
		end
	end
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in)
			idx_q <= 6'h00;
		else if (line_octet_valid_out)
			idx_q <= line_cell_first_out ? 6'h01 : idx_q + 6'h01;
		else
			idx_q <= 6'h00;
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);
	sequence setup_s;
		psel_in && !penable_in;
	endsequence
	sequence idle_head_s;
		line_cell_first_out && line_idle_cell_out;
	endsequence
	chk_apb_one_wait: assert property (setup_s |=> !pready_out ##1 pready_out)
		else $error("pready not in second access cycle");
	chk_err_with_ready: assert property (pslverr_out |-> pready_out)
		else $error("pslverr without pready");
	chk_cell_start: assert property ($rose(line_octet_valid_out) |-> line_cell_first_out)
		else $error("cell began without first marker");
	chk_cell_length: assert property (line_octet_valid_out && idx_q != 6'h34
		|=> line_octet_valid_out && !line_cell_first_out)
		else $error("cell shorter than 53 octets");
	chk_octet_index: assert property (line_octet_valid_out && !line_cell_first_out
		|-> idx_q inside {[1:52]})
		else $error("cell longer than 53 octets");
	chk_idle_gfc: assert property (idle_head_s |-> line_octet_out == {hdr_q[7:4], 4'h0})
		else $error("idle octet 0 wrong");
	chk_idle_vpi: assert property (idle_head_s |=> line_octet_out == 8'h00 ##1 line_octet_out == 8'h00)
		else $error("idle path or channel field not zero");
	chk_idle_pti: assert property (idle_head_s |-> ##3 line_octet_out == {4'h0, hdr_q[3:0]})
		else $error("idle octet 3 wrong");
	chk_idle_payload: assert property (line_octet_valid_out && line_idle_cell_out && idx_q > 6'h04
		|-> line_octet_out == pat_q)
		else $error("idle payload octet wrong");
	chk_idle_steady: assert property (line_octet_valid_out && !line_cell_first_out
		|-> $stable(line_idle_cell_out))
		else $error("idle marker changed mid cell");
	chk_irq_release: assert property ($fell(irq_out) |-> $past(done, 1) || $past(done, 2))
		else $error("irq dropped without register access");
endmodule
bind tx_cell_status_idle_fill tx_cell_asserts u_chk (.clk_in(clk_in), .arst_n_in(arst_n_in),
	.psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
	.pwdata_in(pwdata_in), .pready_out(pready_out), .pslverr_out(pslverr_out),
	.irq_out(irq_out), .line_octet_out(line_octet_out),
	.line_octet_valid_out(line_octet_valid_out), .line_cell_first_out(line_cell_first_out),
	.line_idle_cell_out(line_idle_cell_out));

// ### tb/cell_source_model.sv
`timescale 1ns/100ps
module cell_source_model (
	input  wire logic                       clk_in,
	input  wire logic                       parity_sense_in,
	output logic                            wr_out,
	output logic                            soc_out,
	output logic [tx_cell_pkg::DATA_W-1:0]  data_out,
	output logic                            par_out
);
	initial begin
		wr_out = 1'h0;
		soc_out = 1'h0;
		data_out = 16'h0000;
		par_out = 1'h0;
	end
	// Called just after a rising edge; one word per cycle
	task automatic send(input int words, input int soc_at, input int bad_at);
		logic [31:0] r;
		logic [tx_cell_pkg::DATA_W-1:0] d;
		d = 16'h0000;
		for (int i = 0; i < words; i++) begin
			r = $urandom;
			d = r[tx_cell_pkg::DATA_W-1:0];
			wr_out <= 1'h1;
			soc_out <= (i == soc_at);
			data_out <= d;
			par_out <= (^d) ^ !parity_sense_in ^ (i == bad_at);
			@(posedge clk_in);
		end
		// Released bus shows inverted leftovers so stale data never looks valid
		wr_out <= 1'h0;
		soc_out <= 1'h0;
		data_out <= ~d;
		par_out <= ~par_out;
		@(posedge clk_in);
	endtask
endmodule

// ### tb/tx_cell_status_idle_fill_bench.sv
`timescale 1ns/100ps
module tx_cell_status_idle_fill_bench;
	logic                            clk_in, arst_n_in, psel, penable, pwrite, gmu, slot, sense;
	logic                            pready, pslverr, irq, vld, first, idle, wr, soc, par, err;
	logic [tx_cell_pkg::ADDR_W-1:0]  paddr;
	logic [31:0]                     pwdata, prdata, rd, rnd;
	logic [7:0]                      oct;
	logic [tx_cell_pkg::DATA_W-1:0]  data;
	int                              fail_count, n_compared, unused;
	tx_cell_status_idle_fill dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .psel_in(psel),
		.penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
		.prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
		.tx_write_enable_in(wr), .tx_start_of_cell_in(soc), .tx_cell_data_bus_in(data),
		.tx_parity_in(par), .global_monitor_update_in(gmu), .cell_slot_in(slot),
		.irq_out(irq), .line_octet_out(oct), .line_octet_valid_out(vld),
		.line_cell_first_out(first), .line_idle_cell_out(idle));
	cell_source_model src (.clk_in(clk_in), .parity_sense_in(sense), .wr_out(wr),
		.soc_out(soc), .data_out(data), .par_out(par));
	always #25 clk_in = ~clk_in;
	function automatic logic [7:0] stat_exp(input logic en, input logic x, input logic o);
		return {en, x, o, 5'h08};
	endfunction
	function automatic logic [7:0] head_exp(input logic [7:0] hdr);
		return {hdr[7:4], 4'h0};
	endfunction
	task automatic tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic bail;
		check(32'h0, 32'h1);
		tally_and_finish;
	endtask
	task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd);
		int n;
		n = 0;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= {24'h0, wd};
		@(posedge clk_in);
		penable <= 1'h1;
		do begin
			@(posedge clk_in);
			n++;
		end while (pready !== 1'h1 && n < 20);
		if (pready !== 1'h1)
			bail;
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk_in);
	endtask
	task automatic expect_reg(input logic [7:0] idx, input logic [7:0] exp);
		xfer(1'h0, idx, 8'h00);
		check(rd, {24'h0, exp});
	endtask
	// Bounded wait on irq (0), first octet (1) or octet valid (2)
	task automatic await(input int which, input logic lvl);
		logic s;
		for (int n = 0; n < 80; n++) begin
			s = (which == 0) ? irq : (which == 1) ? first : vld;
			if (s === lvl) begin
				check(s, lvl);
				return;
			end
			@(posedge clk_in);
		end
		bail;
	endtask
	task automatic send_slot(input logic idle_exp, input logic [7:0] oct_exp);
		slot <= 1'h1;
		@(posedge clk_in);
		slot <= 1'h0;
		await(1, 1'h1);
		check(idle, idle_exp);
		check(oct, oct_exp);
		await(2, 1'h0);
	endtask
	task automatic load_pulse;
		gmu <= 1'h1;
		@(posedge clk_in);
		gmu <= 1'h0;
		@(posedge clk_in);
	endtask
	initial begin
		clk_in = 1'h0;
		arst_n_in = 1'h0;
		{psel, penable, pwrite, gmu, slot, sense} = 6'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		fail_count = 0;
		n_compared = 0;
		unused = $urandom(32'h19A3D649);
		repeat (3) @(posedge clk_in);
		arst_n_in <= 1'h1;
		@(posedge clk_in);
		expect_reg(tx_cell_pkg::IDX_CONFIG1, 8'h04);
		expect_reg(tx_cell_pkg::IDX_COUNT_STAT, stat_exp(1'h0, 1'h0, 1'h0));
		expect_reg(tx_cell_pkg::IDX_INT_EN_STAT, 8'h00);
		expect_reg(tx_cell_pkg::IDX_IDLE_HDR, 8'h01);
		expect_reg(tx_cell_pkg::IDX_IDLE_PAY, 8'h6A);
		expect_reg(tx_cell_pkg::IDX_COUNT_LOW, 8'h00);
		xfer(1'h0, 8'h89, 8'h00);
		check(err, 1'h1);
		check(rd, 32'h0);
		for (int i = 0; i < 3; i++) begin
			rnd = $urandom;
			xfer(1'h1, tx_cell_pkg::IDX_IDLE_HDR, rnd[7:0]);
			xfer(1'h1, tx_cell_pkg::IDX_IDLE_PAY, rnd[15:8]);
			expect_reg(tx_cell_pkg::IDX_IDLE_PAY, rnd[15:8]);
			send_slot(1'h1, head_exp(rnd[7:0]));
		end
		xfer(1'h1, tx_cell_pkg::IDX_INT_EN_STAT, 8'hE0);
		src.send(32, 5, -1);
		await(0, 1'h1);
		expect_reg(tx_cell_pkg::IDX_INT_EN_STAT, 8'hE1);
		expect_reg(tx_cell_pkg::IDX_INT_EN_STAT, 8'hE0);
		await(0, 1'h0);
		send_slot(1'h0, 8'h00);
		xfer(1'h1, tx_cell_pkg::IDX_INT_EN_STAT, 8'h00);
		src.send(27, 0, 3);
		repeat (6) @(posedge clk_in);
		check(irq, 1'h0);
		expect_reg(tx_cell_pkg::IDX_INT_EN_STAT, 8'h04);
		sense <= 1'h1;
		xfer(1'h1, tx_cell_pkg::IDX_CONFIG1, 8'h84);
		xfer(1'h1, tx_cell_pkg::IDX_INT_EN_STAT, 8'h80);
		src.send(27, 0, 10);
		await(0, 1'h1);
		expect_reg(tx_cell_pkg::IDX_INT_EN_STAT, 8'h84);
		await(0, 1'h0);
		xfer(1'h1, tx_cell_pkg::IDX_INT_EN_STAT, 8'h40);
		repeat (3) src.send(27, 0, -1);
		await(0, 1'h1);
		expect_reg(tx_cell_pkg::IDX_INT_EN_STAT, 8'h42);
		for (int i = 0; i < 5; i++)
			send_slot(i == 4, (i == 4) ? head_exp(rnd[7:0]) : 8'h00);
		xfer(1'h1, tx_cell_pkg::IDX_COUNT_MID, rnd[23:16]);
		expect_reg(tx_cell_pkg::IDX_COUNT_STAT, stat_exp(1'h0, 1'h1, 1'h0));
		expect_reg(tx_cell_pkg::IDX_COUNT_LOW, 8'h05);
		expect_reg(tx_cell_pkg::IDX_COUNT_HIGH, 8'h00);
		expect_reg(tx_cell_pkg::IDX_COUNT_STAT, stat_exp(1'h0, 1'h0, 1'h0));
		xfer(1'h1, tx_cell_pkg::IDX_COUNT_STAT, 8'h88);
		load_pulse;
		await(0, 1'h1);
		load_pulse;
		expect_reg(tx_cell_pkg::IDX_COUNT_STAT, stat_exp(1'h1, 1'h1, 1'h1));
		expect_reg(tx_cell_pkg::IDX_COUNT_STAT, stat_exp(1'h1, 1'h0, 1'h0));
		await(0, 1'h0);
		expect_reg(tx_cell_pkg::IDX_COUNT_LOW, 8'h00);
		tally_and_finish;
	end
endmodule
